// ---- pit_consts.vh ----
// constants for the prescaled interval timer: register offsets, fields, resets
// assumes a classic wishbone slave with 32-bit data, byte addresses
// Summary of operation
// - 16-bit down-counter decrements once every n+1 processor cycles, n the scale value
// - 8-bit software-writable scale register sets cycles between decrements
// - interrupt request raised when the down-counter reaches zero
// - at zero, counter reloads from the 16-bit period register and continues
`ifndef PIT_CONSTS_VH
`define PIT_CONSTS_VH
`define PIT_ADDR_W        4
`define PIT_OFS_COUNT     4'h0
`define PIT_OFS_SCALE     4'h4
`define PIT_OFS_PERIOD    4'h8
`define PIT_OFS_CTRL      4'hC
`define PIT_CTRL_EN_BIT   0
`define PIT_CTRL_IRQ_BIT  1
`define PIT_RST_COUNT     16'h0000
`define PIT_RST_SCALE     8'h00
`define PIT_RST_PERIOD    16'h0000
`endif

// ---- pit_prescaler.v ----
// cycle prescaler: emits one tick every (scale+1) enabled clocks
// scale changes take effect at once: the running count is compared with the new value
`timescale 1ns/1ps
module pit_prescaler #(
    parameter SCALE_W = 8
) (
    // clock and reset
    input  wire               clk_i,
    input  wire               rst_i,
    // control
    input  wire               en_i,
    input  wire [SCALE_W-1:0] scale_i,
    // tick out
    output wire               tick_o
);
    reg [SCALE_W-1:0] cnt;

    assign tick_o = en_i && (cnt == scale_i);

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= {SCALE_W{1'b0}};
        end else if (en_i) begin
            if (cnt >= scale_i)
                cnt <= {SCALE_W{1'b0}}; // also recovers if scale shrinks
            else
                cnt <= cnt + {{(SCALE_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // pit_prescaler

// ---- pit_timer.v ----
// prescaled interval timer with wishbone register access
// assumes classic wishbone single cycles from a master on clk_i
`timescale 1ns/1ps
`include "pit_consts.vh"
module pit_timer #(
    parameter CNT_W   = 16,
    parameter SCALE_W = 8
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // timer event
    output reg         irq_o
);
    // byte lanes that sel_i can reach in the wide registers
    localparam LANES = CNT_W / 8;

    // event spacing: with scale s and period p the zero event repeats
    // every (p+1)*(s+1) clocks; the extra step is the reload itself,
    // which leaves the counter at the period rather than below it

    // timer state, all cleared by reset
    reg  [CNT_W-1:0]   timer_down_count;
    reg  [SCALE_W-1:0] timer_cycle_scale;
    reg  [CNT_W-1:0]   timer_reload_period;
    reg                enable;
    reg                zero_seen;

    // next values, one per state register
    reg  [CNT_W-1:0]   next_count;
    reg  [SCALE_W-1:0] next_scale;
    reg  [CNT_W-1:0]   next_period;
    reg                next_enable;
    reg                next_zero_seen;
    reg                next_irq;
    reg                next_ack;
    reg  [31:0]        next_dat;

    // bus decode
    wire               req;
    wire               rd_req;
    wire               wr;
    wire               hit_count;
    wire               hit_scale;
    wire               hit_period;
    wire               hit_ctrl;
    wire               clear_req;
    reg  [31:0]        rd_word;

    // write values with untouched byte lanes kept
    wire [CNT_W-1:0]   count_wr_val;
    wire [CNT_W-1:0]   period_wr_val;

    // step decode
    wire               tick;
    wire               step;
    wire               at_zero;
    wire               at_one;
    wire               zero_event;

    // address match, shared by the write and read decoders
    function addr_hit;
        input [3:0] adr;
        input [3:0] ofs;
        begin
            addr_hit = (adr == ofs);
        end
    endfunction

    // zero-extend a 16-bit register into the read word
    function [31:0] pad16;
        input [15:0] val;
        begin
            pad16 = {16'h0000, val};
        end
    endfunction

    // control word read back: enable and sticky zero flag in place
    function [31:0] ctrl_word;
        input en;
        input seen;
        begin
            ctrl_word                    = 32'h00000000;
            ctrl_word[`PIT_CTRL_EN_BIT]  = en;
            ctrl_word[`PIT_CTRL_IRQ_BIT] = seen;
        end
    endfunction

    // a request is taken on the edge where it meets ack low
    assign req    = cyc_i && stb_i && !ack_o;
    assign rd_req = req && !we_i;

    // writes land on the edge where ack is high, the one edge at
    // which the master also sees the cycle complete
    assign wr     = cyc_i && stb_i && we_i && ack_o;

    // register select; unmapped offsets hit nothing and read zero
    assign hit_count  = addr_hit(adr_i, `PIT_OFS_COUNT);
    assign hit_scale  = addr_hit(adr_i, `PIT_OFS_SCALE);
    assign hit_period = addr_hit(adr_i, `PIT_OFS_PERIOD);
    assign hit_ctrl   = addr_hit(adr_i, `PIT_OFS_CTRL);

    // status clear: a one in the flag position of a control write
    assign clear_req  = wr && hit_ctrl && sel_i[0] && dat_i[`PIT_CTRL_IRQ_BIT];

    // byte lanes of count and period each follow their own enable
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            assign count_wr_val[lane*8 +: 8]  = sel_i[lane] ? dat_i[lane*8 +: 8] : timer_down_count[lane*8 +: 8];
            assign period_wr_val[lane*8 +: 8] = sel_i[lane] ? dat_i[lane*8 +: 8] : timer_reload_period[lane*8 +: 8];
        end
    endgenerate

    pit_prescaler #(
        .SCALE_W (SCALE_W)
    ) u_pre (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (enable),
        .scale_i (timer_cycle_scale),
        .tick_o  (tick)
    );

    assign step       = enable && tick;
    assign at_zero    = (timer_down_count == {CNT_W{1'b0}});
    assign at_one     = (timer_down_count == {{(CNT_W-1){1'b0}}, 1'b1});

    // the step that brings the counter from one to zero
    assign zero_event = step && at_one;

    // next counter: step first, a software write then overrides it
    always @* begin
        next_count = timer_down_count;
        if (step) begin
            if (at_zero) begin
                next_count = timer_reload_period;
            end else begin
                next_count = timer_down_count - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
        if (wr && hit_count) begin
            next_count = count_wr_val;
        end
    end

    // counter register
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_down_count <= `PIT_RST_COUNT;
        end else begin
            timer_down_count <= next_count;
        end
    end

    // scale writable through the low lane only
    always @* begin
        next_scale = timer_cycle_scale;
        if (wr && hit_scale && sel_i[0]) begin
            next_scale = dat_i[SCALE_W-1:0];
        end
    end

    // scale register; a new value takes hold at once against the running prescaler count
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_cycle_scale <= `PIT_RST_SCALE;
        end else begin
            timer_cycle_scale <= next_scale;
        end
    end

    always @* begin
        next_period = timer_reload_period;
        if (wr && hit_period) begin
            next_period = period_wr_val;
        end
    end

    // period register; read only at the reload step, so a change
    // never cuts short the count already running
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_reload_period <= `PIT_RST_PERIOD;
        end else begin
            timer_reload_period <= next_period;
        end
    end

    // enable bit of the control word
    always @* begin
        next_enable = enable;
        if (wr && hit_ctrl && sel_i[0]) begin
            next_enable = dat_i[`PIT_CTRL_EN_BIT];
        end
    end

    // enable register; clearing it freezes counter and prescaler alike
    always @(posedge clk_i) begin
        if (rst_i) begin
            enable <= 1'b0;
        end else begin
            enable <= next_enable;
        end
    end

    // sticky zero flag: set wins over a clear in the same cycle, so
    // software never loses an event that lands on its own clear
    always @* begin
        next_zero_seen = zero_seen;
        if (clear_req) begin
            next_zero_seen = 1'b0;
        end
        if (zero_event) begin
            next_zero_seen = 1'b1;
        end
    end

    // zero flag register
    always @(posedge clk_i) begin
        if (rst_i) begin
            zero_seen <= 1'b0;
        end else begin
            zero_seen <= next_zero_seen;
        end
    end

    // request pulse, high for one cycle per zero event
    always @* begin
        next_irq = zero_event;
    end

    // request register
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        rd_word = 32'h00000000;
        if (hit_count) begin
            rd_word = pad16(timer_down_count);
        end
        if (hit_scale) begin
            rd_word = {{(32-SCALE_W){1'b0}}, timer_cycle_scale};
        end
        if (hit_period) begin
            rd_word = pad16(timer_reload_period);
        end
        if (hit_ctrl) begin
            rd_word = ctrl_word(enable, zero_seen);
        end
    end

    // read data is caught when the request is taken and then held
    // until the next read, so it stays valid while ack is high
    always @* begin
        next_dat = dat_o;
        if (rd_req) begin
            next_dat = rd_word;
        end
    end

    // single-wait-state answer: ack one cycle after the request
    always @* begin
        next_ack = req;
    end

    // answer registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

endmodule // pit_timer

// ---- pit_timer_assertions.sv ----
// checker for pit_timer bus answer and timer event
// assumes binding to the pit_timer top module
`timescale 1ns/1ps
module pit_timer_assertions (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request taken, one-cycle answer
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_ack; ack_o ##1 !ack_o; endsequence
    property p_ack; s_req |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack late or long");
    property p_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_cause: assert property (p_cause) else $error("ack unasked");
    // read data only moves on a read
    property p_hold; !(cyc_i && stb_i && !we_i) |=> $stable(dat_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_irq; irq_o |=> !irq_o; endproperty
    a_irq: assert property (p_irq) else $error("irq too long");
    property p_rst; disable iff (1'b0) rst_i |=> !ack_o && !irq_o; endproperty
    a_rst: assert property (p_rst) else $error("busy in reset");
endmodule // pit_timer_assertions
bind pit_timer pit_timer_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

// ---- pit_timer_bench.sv ----
// bench for pit_timer: registers, irq spacing, hold while off
// assumes a one-request classic wishbone slave
`timescale 1ns/1ps
module pit_timer_bench;
    reg         clk_i, rst_i, cyc_i, stb_i, we_i;
    reg  [3:0]  adr_i, sel_i;
    reg  [31:0] dat_i, rv;
    wire [31:0] dat_o;
    wire        ack_o, irq_o;
    integer     err_count = 0, n_checks = 0, i, c;
    pit_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));
    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // one bus cycle, read data left in rv
    task acc(input w, input [3:0] a, input [31:0] d);
        begin
            {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
            do @(posedge clk_i); while (ack_o !== 1'b1);
            rv = dat_o;
            {cyc_i, stb_i} <= 2'h0;
            @(posedge clk_i);
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                $display("[ERR] %s exp %h got %h", n, e, g);
                err_count = err_count + 1;
            end
        end
    endtask
    // cycles up to the next irq pulse
    task wirq;
        begin
            c = 0;
            do begin
                @(posedge clk_i);
                c = c + 1;
            end while (irq_o !== 1'b1 && c < 300);
        end
    endtask
    task give_verdict;
        begin
            $display("errors %0d checks %0d", err_count, n_checks);
            if (err_count == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // hang guard, far beyond the run
    initial begin
        #200000;
        err_count = err_count + 1;
        give_verdict;
    end
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 4'h0, 4'hF, 32'h0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b1, 4'h4, 32'hFFFFFF03);
        acc(1'b0, 4'h4, 32'h0);
        chk("scale", 32'h3, rv);
        acc(1'b0, 4'h1, 32'h0);
        chk("unmapped", 32'h0, rv);
        acc(1'b1, 4'h8, 32'h4);
        // period 4, scale 0 and 3
        for (i = 0; i < 2; i = i + 1) begin
            acc(1'b1, 4'h4, i * 3);
            acc(1'b1, 4'hC, 32'h1);
            wirq;
            wirq;
            chk("irq gap", (i * 3 + 1) * 5, c);
            acc(1'b1, 4'hC, 32'h0);
        end
        acc(1'b0, 4'h8, 32'h0);
        chk("period", 32'h4, rv);
        acc(1'b0, 4'hC, 32'h0);
        chk("ctrl zero seen", 32'h2, rv);
        acc(1'b1, 4'hC, 32'h2);
        acc(1'b0, 4'hC, 32'h0);
        chk("ctrl cleared", 32'h0, rv);
        acc(1'b1, 4'h0, 32'h1234);
        repeat (60) @(posedge clk_i);
        acc(1'b0, 4'h0, 32'h0);
        chk("count held", 32'h1234, rv);
        // mid-run reset clears the counter
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b0, 4'h0, 32'h0);
        chk("count after reset", 32'h0, rv);
        give_verdict;
    end
endmodule // pit_timer_bench
